// ### hw/lsmf_ctrl.sv
// Purpose: Mode, conversion timing, range stepping and status flags of the sensor.
// Assumes: The serial engine outside hands over whole 16-bit reads and writes.
// Notes:   Analog overload and mantissa arrive from the converter, off-clock.
`timescale 1ns/1ps
`default_nettype none
module lsmf_ctrl #(
  parameter int SHORT_CYC = lsmf_pkg::CONV_SHORT_CYC,
  parameter int LONG_CYC  = lsmf_pkg::CONV_LONG_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        cfg_wr,
  input  wire logic [15:0] cfg_wdata,
  input  wire logic        cfg_rd,
  output logic      [15:0] cfg_rdata,
  input  wire logic [15:0] low_limit,
  input  wire logic [15:0] high_limit,
  input  wire logic        adc_overload,
  input  wire logic [11:0] adc_mantissa,
  output logic             conv_run,
  output logic      [3:0]  range_active,
  output logic      [15:0] result_word,
  output logic             result_valid,
  output logic             alert_active
);

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  logic [3:0] range_select_q;
  logic       conversion_duration_choice_q;
  logic [1:0] mode_q;
  logic       overrange_status_q;
  logic       conversion_done_status_q;
  logic       upper_threshold_hit_q;
  logic       lower_threshold_hit_q;
  logic       latch_q;
  logic       pol_q;
  logic       mask_q;
  logic [1:0] fault_count_setting_q;

  lsmf_pkg::lsmf_state_t state_q;
  logic [lsmf_pkg::CNT_W-1:0] cnt_q;
  logic [3:0]  range_q;
  logic        ovl_seen_q;
  logic [15:0] result_q;
  logic        valid_q;
  logic        ovl_s1_q;
  logic        ovl_s2_q;
  logic [11:0] man_s1_q;
  logic [11:0] man_s2_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic                       auto_mode;
  logic                       wr_runs;
  logic                       start_wr;
  logic [lsmf_pkg::CNT_W-1:0] conv_len;
  logic                       at_end;
  logic                       step_up;
  logic                       conv_done;
  logic [1:0]                 drop_bits;
  logic [11:0]                man_mask;
  logic [26:0]                res_val;
  logic [26:0]                lo_val;
  logic [26:0]                hi_val;
  logic                       above;
  logic                       below;
  logic                       upper_reached;
  logic                       lower_reached;
  logic [3:0]                 start_range;
  logic                       ovl_now;

  assign auto_mode = (range_select_q == lsmf_pkg::RANGE_AUTO);
  assign wr_runs   = (cfg_wdata[lsmf_pkg::MODE_HI:lsmf_pkg::MODE_LO] != lsmf_pkg::MODE_OFF);
  assign start_wr  = cfg_wr && wr_runs;

  // A restart through a write uses the newly written range and duration.
  assign start_range = (cfg_wr &&
                        cfg_wdata[lsmf_pkg::RANGE_HI:lsmf_pkg::RANGE_LO] != lsmf_pkg::RANGE_AUTO)
                       ? cfg_wdata[lsmf_pkg::RANGE_HI:lsmf_pkg::RANGE_LO]
                       : ((!cfg_wr && !auto_mode) ? range_select_q : lsmf_pkg::RANGE_ZERO);

  assign conv_len = conversion_duration_choice_q
                    ? lsmf_pkg::CNT_W'(LONG_CYC - 1)
                    : lsmf_pkg::CNT_W'(SHORT_CYC - 1);

  assign at_end  = (state_q == lsmf_pkg::LSMF_CONV) && (cnt_q == conv_len);
  assign ovl_now = ovl_s2_q;

  // Auto range gives up on an overloaded pass at once rather than wasting time.
  assign step_up = (state_q == lsmf_pkg::LSMF_CONV) && !cfg_wr && auto_mode &&
                   ovl_now && (range_q < lsmf_pkg::RANGE_MAX);
  assign conv_done = at_end && !cfg_wr && !step_up;

  // ----------------------------------------------------------------
  // Resolution and comparison
  // ----------------------------------------------------------------
  always_comb begin
    drop_bits = 2'h0;
    if (!conversion_duration_choice_q && range_q <= lsmf_pkg::RANGE_ONE) begin
      if (range_q == lsmf_pkg::RANGE_ONE) begin
        drop_bits = 2'h1;
      end else if (range_q == lsmf_pkg::RANGE_ZERO) begin
        drop_bits = 2'h3;
      end else begin
        drop_bits = 2'h2;
      end
    end
  end

  // Low bits are cleared, not shifted, so the LSB weight stays put.
  assign man_mask = 12'hfff << drop_bits;

  assign res_val = {15'h0000, man_s2_q & man_mask} << range_q;
  assign lo_val  = {15'h0000, low_limit[11:0]} << low_limit[15:12];
  assign hi_val  = {15'h0000, high_limit[11:0]} << high_limit[15:12];
  assign above   = (res_val > hi_val);
  assign below   = (res_val < lo_val);

  lsmf_fault_cnt u_upper (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sample  (conv_done),
    .hit     (above),
    .fc_code (fault_count_setting_q),
    .reached (upper_reached)
  );

  lsmf_fault_cnt u_lower (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sample  (conv_done),
    .hit     (below),
    .fc_code (fault_count_setting_q),
    .reached (lower_reached)
  );

  // ----------------------------------------------------------------
  // Converter input synchronisers
  // ----------------------------------------------------------------
  // The mantissa is stable by the end of a pass, so a plain two-stage
  // capture is enough; it is only used at the end.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovl_s1_q <= 1'b0;
      ovl_s2_q <= 1'b0;
      man_s1_q <= 12'h000;
      man_s2_q <= 12'h000;
    end else begin
      ovl_s1_q <= adc_overload;
      ovl_s2_q <= ovl_s1_q;
      man_s1_q <= adc_mantissa;
      man_s2_q <= man_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= lsmf_pkg::LSMF_IDLE;
      cnt_q   <= '0;
      range_q <= lsmf_pkg::RANGE_ZERO;
    end else if (cfg_wr) begin
      cnt_q   <= '0;
      range_q <= start_range;
      state_q <= start_wr ? lsmf_pkg::LSMF_CONV : lsmf_pkg::LSMF_IDLE;
    end else if (step_up) begin
      cnt_q   <= '0;
      range_q <= range_q + 4'h1;
    end else if (conv_done) begin
      cnt_q <= '0;
      if (mode_q[1]) begin
        range_q <= auto_mode ? lsmf_pkg::RANGE_ZERO : range_select_q;
        state_q <= lsmf_pkg::LSMF_CONV;
      end else begin
        state_q <= lsmf_pkg::LSMF_IDLE;
      end
    end else if (state_q == lsmf_pkg::LSMF_CONV) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Overload seen at any time in a pass counts, even if it fades away.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovl_seen_q <= 1'b0;
    end else if (cfg_wr || step_up || conv_done) begin
      ovl_seen_q <= 1'b0;
    end else if (state_q == lsmf_pkg::LSMF_CONV && ovl_now) begin
      ovl_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Host-writable fields
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      range_select_q               <= lsmf_pkg::RANGE_RST;
      conversion_duration_choice_q <= lsmf_pkg::DUR_RST;
      latch_q                      <= lsmf_pkg::LATCH_RST;
      pol_q                        <= 1'b0;
      mask_q                       <= 1'b0;
      fault_count_setting_q        <= 2'h0;
    end else if (cfg_wr) begin
      range_select_q               <= cfg_wdata[lsmf_pkg::RANGE_HI:lsmf_pkg::RANGE_LO];
      conversion_duration_choice_q <= cfg_wdata[lsmf_pkg::DUR_BIT];
      latch_q                      <= cfg_wdata[lsmf_pkg::LATCH_BIT];
      pol_q                        <= cfg_wdata[lsmf_pkg::POL_BIT];
      mask_q                       <= cfg_wdata[lsmf_pkg::MASK_BIT];
      fault_count_setting_q        <= cfg_wdata[lsmf_pkg::FC_HI:lsmf_pkg::FC_LO];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= lsmf_pkg::MODE_RST;
    end else if (cfg_wr) begin
      mode_q <= cfg_wdata[lsmf_pkg::MODE_HI:lsmf_pkg::MODE_LO];
    end else if (conv_done && mode_q == lsmf_pkg::MODE_SINGLE) begin
      mode_q <= lsmf_pkg::MODE_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overrange_status_q <= 1'b0;
    end else if (conv_done) begin
      // In auto range a pass only ends overloaded at the top range.
      overrange_status_q <= ovl_seen_q || ovl_now;
    end
  end

  // Completion wins over a read that lands in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conversion_done_status_q <= 1'b0;
    end else if (conv_done) begin
      conversion_done_status_q <= 1'b1;
    end else if (cfg_rd || (cfg_wr && wr_runs)) begin
      conversion_done_status_q <= 1'b0;
    end
  end

  // Latched flags hold until a register read; transparent ones follow each
  // measurement. Nothing here looks at the mode, so shutdown keeps them.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      upper_threshold_hit_q <= 1'b0;
      lower_threshold_hit_q <= 1'b0;
    end else if (conv_done) begin
      upper_threshold_hit_q <= upper_reached ||
                               (latch_q && upper_threshold_hit_q && !cfg_rd);
      lower_threshold_hit_q <= lower_reached ||
                               (latch_q && lower_threshold_hit_q && !cfg_rd);
    end else if (cfg_rd && latch_q) begin
      upper_threshold_hit_q <= 1'b0;
      lower_threshold_hit_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Result
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_q <= 16'h0000;
      valid_q  <= 1'b0;
    end else begin
      valid_q <= conv_done;
      if (conv_done) begin
        if (mask_q && !auto_mode) begin
          result_q <= {4'h0, man_s2_q & man_mask};
        end else begin
          result_q <= {range_q, man_s2_q & man_mask};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_rdata = {range_select_q, conversion_duration_choice_q, mode_q,
                      overrange_status_q, conversion_done_status_q,
                      upper_threshold_hit_q, lower_threshold_hit_q,
                      latch_q, pol_q, mask_q, fault_count_setting_q};

  assign conv_run     = (state_q == lsmf_pkg::LSMF_CONV);
  assign range_active = range_q;
  assign result_word  = result_q;
  assign result_valid = valid_q;
  // Polarity is applied at the pad driver outside this block.
  assign alert_active = upper_threshold_hit_q || lower_threshold_hit_q;

endmodule
`default_nettype wire

// ### common/lsmf_pkg.sv
// Purpose: Constants shared by the light sensor mode and flag control block.
// Assumes: 10 MHz system clock; config register reached through a word port.
// Notes:   Field positions and reset values of the sensor control register.
package lsmf_pkg;

  // ----------------------------------------------------------------
  // Register fields
  // ----------------------------------------------------------------
  localparam int RANGE_HI   = 15;
  localparam int RANGE_LO   = 12;
  localparam int DUR_BIT    = 11;
  localparam int MODE_HI    = 10;
  localparam int MODE_LO    = 9;
  localparam int OVR_BIT    = 8;
  localparam int DONE_BIT   = 7;
  localparam int UPPER_BIT  = 6;
  localparam int LOWER_BIT  = 5;
  localparam int LATCH_BIT  = 4;
  localparam int POL_BIT    = 3;
  localparam int MASK_BIT   = 2;
  localparam int FC_HI      = 1;
  localparam int FC_LO      = 0;

  localparam logic [3:0] RANGE_RST  = 4'hc;
  localparam logic       DUR_RST    = 1'b1;
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic       LATCH_RST  = 1'b1;
  localparam logic [3:0] RANGE_AUTO = 4'hc;
  localparam logic [3:0] RANGE_MAX  = 4'hb;
  localparam logic [3:0] RANGE_ONE  = 4'h5;
  localparam logic [3:0] RANGE_ZERO = 4'h0;

  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ       = 10000;
  localparam int CONV_SHORT_MS = 100;
  localparam int CONV_LONG_MS  = 800;
  localparam int CONV_SHORT_CYC = CONV_SHORT_MS * CLK_KHZ;
  localparam int CONV_LONG_CYC  = CONV_LONG_MS * CLK_KHZ;
  localparam int CNT_W          = 23;

  typedef enum logic {LSMF_IDLE, LSMF_CONV} lsmf_state_t;

endpackage

// ### hw/lsmf_fault_cnt.sv
// Purpose: Counts consecutive threshold hits and reports when enough occur.
// Assumes: One sample pulse per finished measurement.
// Notes:   Count saturates at eight so it never wraps back below the need.
`timescale 1ns/1ps
`default_nettype none
module lsmf_fault_cnt (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       sample,
  input  wire logic       hit,
  input  wire logic [1:0] fc_code,
  output logic            reached
);

  logic [3:0] run_q;
  logic [3:0] need;
  logic [3:0] run_d;

  always_comb begin
    case (fc_code)
      2'h0:    need = 4'h1;
      2'h1:    need = 4'h2;
      2'h2:    need = 4'h4;
      default: need = 4'h8;
    endcase
  end

  always_comb begin
    run_d = run_q;
    if (sample) begin
      if (!hit) begin
        run_d = 4'h0;
      end else if (run_q != 4'h8) begin
        run_d = run_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_q <= 4'h0;
    end else begin
      run_q <= run_d;
    end
  end

  assign reached = (run_d >= need);

endmodule
`default_nettype wire

// ### testbench/lsmf_ctrl_sva.sv
// Purpose: Port checks of lsmf_ctrl.
// Assumes: One clock, synchronous reset.
// Notes:   A completing pass wins over a read clear.
`timescale 1ns/1ps
`default_nettype none
module lsmf_ctrl_sva (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        cfg_wr,
  input wire logic [15:0] cfg_wdata,
  input wire logic        cfg_rd,
  input wire logic [15:0] cfg_rdata,
  input wire logic        conv_run,
  input wire logic        result_valid,
  input wire logic        alert_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_fields_write: assert property (cfg_wr |=> cfg_rdata[15:9] == $past(cfg_wdata[15:9]))
    else $error("written fields not shown");
  a_ready_rise: assert property ($rose(cfg_rdata[7]) |-> result_valid)
    else $error("ready rose without a result");
  a_ready_done: assert property (result_valid |-> cfg_rdata[7])
    else $error("result without ready");
  a_read_clear: assert property (cfg_rd |=> !cfg_rdata[7] || result_valid)
    else $error("read left ready set");
  a_write_clear: assert property (cfg_wr && cfg_wdata[10:9] != 2'h0 |=> !cfg_rdata[7])
    else $error("run write left ready set");
  a_off_keeps: assert property (cfg_wr && cfg_wdata[10:9] == 2'h0 && !cfg_rd
    |=> $stable(cfg_rdata[7:5]))
    else $error("shutdown write changed flags");
  a_ovf_steady: assert property (!result_valid |-> $stable(cfg_rdata[8]))
    else $error("overflow changed without result");
  a_single_clear: assert property ($fell(conv_run) && $past(cfg_rdata[10:9]) == 2'h1
    && !$past(cfg_wr) |-> cfg_rdata[10:9] == 2'h0)
    else $error("single shot mode not cleared");
  a_start_run: assert property (cfg_wr && cfg_wdata[10:9] != 2'h0 |=> conv_run)
    else $error("write did not start a pass");
  a_abort_wr: assert property (cfg_wr |=> !result_valid)
    else $error("aborted pass gave a result");
  a_alert_or: assert property (alert_active == (cfg_rdata[6] || cfg_rdata[5]))
    else $error("alert differs from flags");
endmodule
`default_nettype wire

// ### testbench/lsmf_conv_model.sv
// Purpose: Behavioural converter in front of lsmf_ctrl.
// Assumes: Overload depends only on the range in use.
// Notes:   Between passes the mantissa lines show the inverse value.
`timescale 1ns/1ps
`default_nettype none
module lsmf_conv_model (
  input  wire logic        sys_clk,
  input  wire logic        conv_run,
  input  wire logic [3:0]  range_active,
  input  wire logic [4:0]  ovl_upto,
  input  wire logic [11:0] mant,
  output logic             adc_overload,
  output logic      [11:0] adc_mantissa
);
  logic [7:0] age_q;
  logic [3:0] rng_q;
  always_ff @(posedge sys_clk) begin
    rng_q <= range_active;
    if (!conv_run || range_active != rng_q) begin
      age_q <= 8'h00;
    end else if (age_q != 8'hff) begin
      age_q <= age_q + 8'h01;
    end
  end
  // One short overload per range, so each step is seen once.
  assign adc_overload = conv_run && age_q == 8'h04 && ({1'b0, range_active} < ovl_upto);
  assign adc_mantissa = conv_run ? mant : ~mant;
endmodule
`default_nettype wire

// ### testbench/light_sensor_mode_and_flag_control_tb_top.sv
// Purpose: Self-checking bench of lsmf_ctrl.
// Assumes: Passes shortened to 20 and 160 cycles.
// Notes:   The converter is lsmf_conv_model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module light_sensor_mode_and_flag_control_tb_top;
  localparam int SHORT = 20;
  localparam int LONG  = 160;
  logic        sys_clk     = 1'b0;
  logic        rst         = 1'b1;
  logic        cfg_wr      = 1'b0;
  logic [15:0] cfg_wdata   = 16'h0000;
  logic        cfg_rd      = 1'b0;
  logic [15:0] low_limit   = 16'h0000;
  logic [15:0] high_limit  = 16'hbfff;
  logic [4:0]  ovl_upto    = 5'h00;
  logic [11:0] mant        = 12'h5a7;
  logic        adc_overload;
  logic [11:0] adc_mantissa;
  logic [15:0] cfg_rdata;
  logic [15:0] result_word;
  logic        conv_run;
  logic        result_valid;
  logic        alert_active;
  logic [3:0]  range_active;
  logic        got;
  int          mismatches  = 0;
  int          checks_done = 0;
  int          n;
  logic [3:0]  rtab [5]    = '{4'h0, 4'h1, 4'h5, 4'h6, 4'hb};
  logic [11:0] mtab [5]    = '{12'h5a0, 12'h5a4, 12'h5a6, 12'h5a7, 12'h5a7};
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  lsmf_ctrl #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) DUT (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .cfg_wr       (cfg_wr),
    .cfg_wdata    (cfg_wdata),
    .cfg_rd       (cfg_rd),
    .cfg_rdata    (cfg_rdata),
    .low_limit    (low_limit),
    .high_limit   (high_limit),
    .adc_overload (adc_overload),
    .adc_mantissa (adc_mantissa),
    .conv_run     (conv_run),
    .range_active (range_active),
    .result_word  (result_word),
    .result_valid (result_valid),
    .alert_active (alert_active)
  );
  lsmf_conv_model u_conv (
    .sys_clk      (sys_clk),
    .conv_run     (conv_run),
    .range_active (range_active),
    .ovl_upto     (ovl_upto),
    .mant         (mant),
    .adc_overload (adc_overload),
    .adc_mantissa (adc_mantissa)
  );
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  function automatic logic [15:0] cw(logic [3:0] r, logic d, logic [1:0] m, logic l,
                                     logic [1:0] fc);
    return {r, d, m, 4'h0, l, 2'h0, fc};
  endfunction
  task automatic wr(input logic [15:0] d);
    @(posedge sys_clk);
    cfg_wr    <= 1'b1;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd();
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
  endtask
  task automatic wait_done(input int limit);
    n   = 0;
    got = 1'b0;
    for (int i = 0; i < limit; i++) begin
      @(posedge sys_clk);
      if (result_valid === 1'b1) begin
        got = 1'b1;
        break;
      end
      if (conv_run === 1'b1) n++;
    end
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    `CHK("reset word", 16'hc810, cfg_rdata);
    for (int i = 0; i < 5; i++) begin
      wr(cw(rtab[i], 1'b0, 2'h1, 1'b1, 2'h0) | 16'h01e0);
      `CHK("mode running", 2'h1, cfg_rdata[10:9]);
      `CHK("status bits", 4'h0, cfg_rdata[8:5]);
      wait_done(100);
      `CHK("short length", SHORT, n);
      `CHK("result", {rtab[i], mtab[i]}, result_word);
      `CHK("single end", 3'h1, {cfg_rdata[10:9], cfg_rdata[7]});
    end
    wr(cw(4'h6, 1'b1, 2'h0, 1'b1, 2'h0));
    `CHK("ready kept", 1'b1, cfg_rdata[7]);
    rd();
    `CHK("ready read", 1'b0, cfg_rdata[7]);
    wr(cw(4'h6, 1'b1, 2'h1, 1'b1, 2'h0));
    wait_done(400);
    `CHK("long length", LONG, n);
    `CHK("long result", {4'h6, 12'h5a7}, result_word);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      ovl_upto <= i ? 5'h00 : 5'h1f;
      wr(cw(4'h2, 1'b0, 2'h1, 1'b1, 2'h0));
      wait_done(100);
      `CHK("manual overflow", ~i[0], cfg_rdata[8]);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      ovl_upto <= i ? 5'h0c : 5'h04;
      wr(cw(4'hc, 1'b0, 2'h1, 1'b1, 2'h0));
      wait_done(400);
      `CHK("auto exponent", i ? 4'hb : 4'h4, result_word[15:12]);
      `CHK("auto range", i ? 4'hb : 4'h4, range_active);
      `CHK("auto overflow", i[0], cfg_rdata[8]);
    end
    @(posedge sys_clk);
    ovl_upto   <= 5'h00;
    high_limit <= 16'h6100;
    wr(cw(4'h6, 1'b0, 2'h2, 1'b1, 2'h1));
    wait_done(100);
    `CHK("upper one", 1'b0, cfg_rdata[6]);
    wait_done(100);
    `CHK("upper two", 2'h3, {cfg_rdata[6], alert_active});
    `CHK("continuous", 3'h6, {conv_run, cfg_rdata[10:9]});
    @(posedge sys_clk);
    high_limit <= 16'hbfff;
    low_limit  <= 16'h6fff;
    wr(cw(4'h6, 1'b0, 2'h3, 1'b0, 2'h0));
    wait_done(100);
    `CHK("lower flag", 2'h1, cfg_rdata[6:5]);
    repeat (5) @(posedge sys_clk);
    // The mask bit is set here so that a manual range hides the exponent.
    wr(cw(4'h6, 1'b0, 2'h3, 1'b0, 2'h0) | 16'h0004);
    wait_done(100);
    `CHK("restart length", SHORT, n);
    `CHK("masked exponent", 16'h05a7, result_word);
    repeat (5) @(posedge sys_clk);
    wr(cw(4'h6, 1'b0, 2'h0, 1'b0, 2'h0));
    wait_done(40);
    `CHK("aborted pass", 1'b0, got);
    `CHK("flags kept", 2'h1, cfg_rdata[6:5]);
    final_report();
  end
  // The tests need about 650 cycles; 4000 leaves a wide margin.
  initial begin
    #(100 * 4000);
    mismatches++;
    final_report();
  end
endmodule
bind lsmf_ctrl lsmf_ctrl_sva u_sva (
  .sys_clk      (sys_clk),
  .rst          (rst),
  .cfg_wr       (cfg_wr),
  .cfg_wdata    (cfg_wdata),
  .cfg_rd       (cfg_rd),
  .cfg_rdata    (cfg_rdata),
  .conv_run     (conv_run),
  .result_valid (result_valid),
  .alert_active (alert_active)
);
`default_nettype wire
